// ---- design/dcpd_regs.vh ----
`ifndef DCPD_REGS_VH
`define DCPD_REGS_VH

// ----------------------------------------------------------------
// Register map (page and byte address of the write command)
// ----------------------------------------------------------------
`define DCPD_REG_PAGE        8'h00
`define DCPD_CORE1_PWR_ADDR  8'h08
`define DCPD_CORE2_PWR_ADDR  8'h0A

// ----------------------------------------------------------------
// Field positions and reset value of each core powerdown register
// ----------------------------------------------------------------
`define DCPD_PD_BIT          0
`define DCPD_PU_BIT          1
`define DCPD_REG_RESET       16'h0000

// ----------------------------------------------------------------
// Core vectors
// ----------------------------------------------------------------
`define DCPD_PD_VECTOR       16'h0004
`define DCPD_HOUSEKEEP_ADDR  16'h002C
`define DCPD_RESET_VECTOR    20'h10000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DCPD_CLK_PERIOD_NS   4
`define DCPD_SYNC_PULSE_NS   1000
`define DCPD_SYNC_CYCLES     (`DCPD_SYNC_PULSE_NS / `DCPD_CLK_PERIOD_NS)
`define DCPD_OSC_SETTLE_CYC  2000
`define DCPD_PLL_LOCK_CYC    1000
`define DCPD_POR_SHORT_CYC   5

`endif

// ---- design/dcpd_core.v ----
// ----------------------------------------------------------------
// Per-core powerdown sequencer
// ----------------------------------------------------------------
module dcpd_core (
  input  wire i_clk,        // System clock
  input  wire i_rstn,       // Async reset, active low
  input  wire i_pd_wr,      // Write of one to the power-down bit
  input  wire i_pu_wr,      // Write of one to the power-up bit
  input  wire i_idle,       // Core executes IDLE
  input  wire i_rti,        // Core executes return from interrupt
  input  wire i_pll_stable, // Shared clock generator running and stable
  output reg  o_irq,        // Powerdown interrupt request, one cycle
  output reg  o_clk_en,     // Core clock enable
  output wire o_parked,     // Core is powered down
  output wire o_waking,     // Core waits for the clock generator
  output wire o_pd_bit,     // Power-down readback
  output wire o_pu_bit      // Power-up readback
);

  localparam [4:0] S_RUN  = 5'h01;
  localparam [4:0] S_HDL  = 5'h02;
  localparam [4:0] S_PDN  = 5'h04;
  localparam [4:0] S_WAKE = 5'h08;
  localparam [4:0] S_POST = 5'h10;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg       pu_pend_q;
  reg       pu_pend_d;
  reg       reenter_q;
  reg       reenter_d;
  reg       irq_d;

  always @* begin
    state_d   = state_q;
    pu_pend_d = pu_pend_q;
    reenter_d = reenter_q;
    irq_d     = 1'b0;
    case (state_q)
      S_RUN: begin
        if (i_pd_wr) begin
          state_d = S_HDL;
          irq_d   = 1'b1;
        end
      end
      S_HDL: begin
        // A second power-down write here is dropped to avoid nested handlers
        if (i_pu_wr)
          pu_pend_d = 1'b1;
        if (i_rti) begin
          state_d   = S_RUN;
          pu_pend_d = 1'b0;
        end else if (i_idle) begin
          pu_pend_d = 1'b0;
          if (pu_pend_q || i_pu_wr)
            state_d = S_POST;
          else
            state_d = S_PDN;
        end
      end
      S_PDN: begin
        if (i_pu_wr)
          state_d = S_WAKE;
      end
      S_WAKE: begin
        // A power-down during power-up is kept for the return
        if (i_pd_wr)
          reenter_d = 1'b1;
        if (i_pll_stable)
          state_d = S_POST;
      end
      S_POST: begin
        if (i_pd_wr)
          reenter_d = 1'b1;
        if (i_rti) begin
          reenter_d = 1'b0;
          if (reenter_q || i_pd_wr) begin
            state_d = S_HDL;
            irq_d   = 1'b1;
          end else begin
            state_d = S_RUN;
          end
        end
      end
      default: begin
        state_d = S_RUN;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q   <= S_RUN;
      pu_pend_q <= 1'b0;
      reenter_q <= 1'b0;
      o_irq     <= 1'b0;
      o_clk_en  <= 1'b1;
    end else begin
      state_q   <= state_d;
      pu_pend_q <= pu_pend_d;
      reenter_q <= reenter_d;
      o_irq     <= irq_d;
      // Registers and memory keep their contents; only the clock stops
      o_clk_en  <= (state_d == S_RUN) || (state_d == S_HDL)
                || (state_d == S_POST);
    end
  end

  assign o_parked = (state_q == S_PDN);
  assign o_waking = (state_q == S_WAKE);
  assign o_pd_bit = o_parked || o_waking || !i_pll_stable;
  assign o_pu_bit = (state_q != S_RUN);

endmodule

// ---- design/dcpd_ctrl.v ----
`include "dcpd_regs.vh"

module dcpd_ctrl #(
  parameter LOCK_SLOW_CYC = `DCPD_OSC_SETTLE_CYC + `DCPD_PLL_LOCK_CYC,
  parameter LOCK_FAST_CYC = `DCPD_PLL_LOCK_CYC
) (
  input  wire        i_clk,               // System clock, 250 MHz
  input  wire        i_rstn,              // Power-on reset pin, active low
  input  wire        i_reg_wr,            // Register write command strobe
  input  wire        i_reg_rd,            // Register read strobe
  input  wire [7:0]  i_reg_page,          // Register page
  input  wire [7:0]  i_reg_addr,          // Register address
  input  wire [15:0] i_reg_wdata,         // Write data
  output reg  [15:0] o_reg_rdata,         // Read data
  output reg         o_reg_rvalid,        // Read data valid, one cycle
  input  wire [1:0]  i_core_idle,         // Core executes IDLE
  input  wire [1:0]  i_core_rti,          // Core executes return from interrupt
  output wire [1:0]  o_core_irq,          // Powerdown interrupt per core
  output wire [1:0]  o_core_clk_en,       // Core clock enable
  output reg  [15:0] o_pd_vector,         // Powerdown interrupt vector
  output reg  [19:0] o_reset_vector,      // Start address after reset
  input  wire        i_boot_mode,         // Boot mode selected
  output reg         o_boot_start,        // Start boot, one cycle after reset
  input  wire        i_crystal_force_on,  // Keep oscillator running
  output reg         o_pll_en,            // Shared clock generator enable
  output reg         o_xtal_en,           // Crystal oscillator enable
  output reg         o_mem_access_ok,     // Host may access core memory
  input  wire        i_usb_suspend,       // USB suspend bus state (pin)
  output reg         o_usb_clk_en,        // Internal USB clock enable
  input  wire        i_pme_enable,        // Wake events enabled
  input  wire        i_wake_event,        // External wake event (pin)
  output reg         o_pme_n,             // Power management event, active low
  output reg         o_platform_shutdown, // Platform in shutdown state
  input  wire        i_link_enable,       // Link enable bit
  input  wire        i_link_cold_req,     // Put link into cold reset
  input  wire        i_link_warm_req,     // Put link into warm reset
  input  wire        i_bitclk_internal,   // Bit clock made on chip
  input  wire        i_bit_clock_ok,      // Bit clock running (pin)
  output reg         o_codec_reset_n,     // Codec reset out, active low
  output reg         o_sync,              // SYNC output
  output reg         o_bit_clock_gen_enable, // Bit clock generator enable
  output reg         o_sync_gen_enable,   // Sync pulse generator enable
  output reg         o_link_ok,           // Link running
  output reg         o_cold_reset_control // Cold reset control bit
);

  // ----------------------------------------------------------------
  // Counter loads
  // ----------------------------------------------------------------
  // Loads are held at full width and cut on purpose below; a lock count
  // above 4095 cycles would need a wider counter.
  localparam [31:0] SYNC_CYC_W  = `DCPD_SYNC_CYCLES;
  localparam [31:0] LOCK_SLOW_W = LOCK_SLOW_CYC;
  localparam [31:0] LOCK_FAST_W = LOCK_FAST_CYC;

  localparam [8:0]  SYNC_CYC  = SYNC_CYC_W[8:0];
  localparam [11:0] LOCK_SLOW = LOCK_SLOW_W[11:0];
  localparam [11:0] LOCK_FAST = LOCK_FAST_W[11:0];

  // ----------------------------------------------------------------
  // Link sequencer states
  // ----------------------------------------------------------------
  localparam [4:0] L_COLD = 5'h01;
  localparam [4:0] L_WARM = 5'h02;
  localparam [4:0] L_SYNC = 5'h04;
  localparam [4:0] L_BCW  = 5'h08;
  localparam [4:0] L_RUN  = 5'h10;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Only the second stage is read; the first may still be settling
  reg [2:0] meta_q;
  reg [2:0] sync_q;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {i_bit_clock_ok, i_wake_event, i_usb_suspend};
      sync_q <= meta_q;
    end
  end

  wire usb_susp_s = sync_q[0];
  wire wake_s     = sync_q[1];
  wire bit_clock_ok_s     = sync_q[2];

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  function hit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (page == `DCPD_REG_PAGE) && (addr == target);
    end
  endfunction

  wire sel1 = hit(i_reg_page, i_reg_addr, `DCPD_CORE1_PWR_ADDR);
  wire sel2 = hit(i_reg_page, i_reg_addr, `DCPD_CORE2_PWR_ADDR);
  // Only bits written as one act, so a zero leaves that core alone
  wire [1:0] pd_wr = {2{i_reg_wr}} & {sel2, sel1} & {2{i_reg_wdata[`DCPD_PD_BIT]}};
  wire [1:0] pu_wr = {2{i_reg_wr}} & {sel2, sel1} & {2{i_reg_wdata[`DCPD_PU_BIT]}};

  // ----------------------------------------------------------------
  // Cores
  // ----------------------------------------------------------------
  reg        pll_stable_q;
  wire [1:0] parked;
  wire [1:0] waking;
  wire [1:0] pd_bit;
  wire [1:0] pu_bit;

  // Each core keeps its own sequencer; only the lock state is shared
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_core
      dcpd_core u_core (
        .i_clk        (i_clk),
        .i_rstn       (i_rstn),
        .i_pd_wr      (pd_wr[g]),
        .i_pu_wr      (pu_wr[g]),
        .i_idle       (i_core_idle[g]),
        .i_rti        (i_core_rti[g]),
        .i_pll_stable (pll_stable_q),
        .o_irq        (o_core_irq[g]),
        .o_clk_en     (o_core_clk_en[g]),
        .o_parked     (parked[g]),
        .o_waking     (waking[g]),
        .o_pd_bit     (pd_bit[g]),
        .o_pu_bit     (pu_bit[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  // Unused bits and unmapped addresses read zero
  function [15:0] pwr_word;
    input pd;
    input pu;
    begin
      pwr_word = `DCPD_REG_RESET;
      pwr_word[`DCPD_PD_BIT] = pd;
      pwr_word[`DCPD_PU_BIT] = pu;
    end
  endfunction

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata  <= `DCPD_REG_RESET;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        if (sel1)
          o_reg_rdata <= pwr_word(pd_bit[0], pu_bit[0]);
        else if (sel2)
          o_reg_rdata <= pwr_word(pd_bit[1], pu_bit[1]);
        else
          o_reg_rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared clock generator
  // ----------------------------------------------------------------
  // Lock time is counted on the system clock; a forced-on crystal skips
  // the oscillator settling share of the wait.
  reg  [11:0] lock_cnt_q;
  wire        all_parked = &parked;
  wire        gen_on     = !all_parked;
  // Reloaded every cycle while both cores sit parked, so a late crystal change counts
  wire [11:0] lock_load  = i_crystal_force_on ? LOCK_FAST : LOCK_SLOW;

  // Out of reset the generator counts as locked, so the cores start at once
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pll_en     <= 1'b1;
      pll_stable_q <= 1'b1;
      lock_cnt_q   <= 12'h000;
    end else begin
      o_pll_en <= gen_on;
      if (!gen_on) begin
        pll_stable_q <= 1'b0;
        lock_cnt_q   <= lock_load;
      end else if (!pll_stable_q) begin
        if (lock_cnt_q <= 12'h001)
          pll_stable_q <= 1'b1;
        else
          lock_cnt_q <= lock_cnt_q - 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Codec link sequencing
  // ----------------------------------------------------------------
  reg [4:0] lstate_q;
  reg [8:0] sync_cnt_q;
  reg       link_enable_q;
  // Only a rising enable acts, so a held level cannot restart the link
  wire      link_enable_rise = i_link_enable && !link_enable_q;
  // An enable while the link already runs is dropped
  wire      link_enable_act  = link_enable_rise && !o_link_ok;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lstate_q               <= L_COLD;
      sync_cnt_q             <= 9'h000;
      link_enable_q                 <= 1'b0;
      o_codec_reset_n        <= 1'b0;
      o_sync                 <= 1'b0;
      o_bit_clock_gen_enable <= 1'b0;
      o_sync_gen_enable      <= 1'b0;
      o_link_ok              <= 1'b0;
      o_cold_reset_control   <= 1'b1;
    end else begin
      link_enable_q <= i_link_enable;
      // Requests override any state; cold wins when both come together
      if (i_link_cold_req) begin
        lstate_q               <= L_COLD;
        o_codec_reset_n        <= 1'b0;
        o_cold_reset_control   <= 1'b1;
        o_sync                 <= 1'b0;
        o_bit_clock_gen_enable <= 1'b0;
        o_sync_gen_enable      <= 1'b0;
        o_link_ok              <= 1'b0;
      end else if (i_link_warm_req) begin
        lstate_q               <= L_WARM;
        o_sync                 <= 1'b0;
        o_bit_clock_gen_enable <= 1'b0;
        o_sync_gen_enable      <= 1'b0;
        o_link_ok              <= 1'b0;
      end else begin
        case (lstate_q)
          L_COLD: begin
            if (link_enable_act) begin
              o_codec_reset_n        <= 1'b1;
              o_cold_reset_control   <= 1'b0;
              o_bit_clock_gen_enable <= i_bitclk_internal;
              lstate_q               <= L_BCW;
            end
          end
          L_WARM: begin
            if (link_enable_act) begin
              o_sync     <= 1'b1;
              sync_cnt_q <= SYNC_CYC - 9'h001;
              lstate_q   <= L_SYNC;
            end
          end
          L_SYNC: begin
            if (sync_cnt_q == 9'h000) begin
              o_sync                 <= 1'b0;
              o_bit_clock_gen_enable <= i_bitclk_internal;
              lstate_q               <= L_BCW;
            end else begin
              sync_cnt_q <= sync_cnt_q - 9'h001;
            end
          end
          L_BCW: begin
            // External bit clock: the primary codec starts it on its own
            if (bit_clock_ok_s) begin
              o_sync_gen_enable <= 1'b1;
              lstate_q          <= L_RUN;
            end
          end
          L_RUN: begin
            o_link_ok <= 1'b1;
            // Further enables while running are ignored
          end
          default: begin
            lstate_q <= L_COLD;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Platform state, USB suspend, wake, reset entry
  // ----------------------------------------------------------------
  wire link_down = lstate_q[0] || lstate_q[1];
  // A forced-on crystal keeps the platform out of shutdown
  wire shutdown  = all_parked && link_down && !i_crystal_force_on;
  // Boot start fires once, on the first edge after reset
  reg  first_q;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_platform_shutdown <= 1'b0;
      o_xtal_en           <= 1'b1;
      o_usb_clk_en        <= 1'b1;
      o_pme_n             <= 1'b1;
      o_mem_access_ok     <= 1'b0;
      o_pd_vector         <= `DCPD_PD_VECTOR;
      o_reset_vector      <= `DCPD_RESET_VECTOR;
      o_boot_start        <= 1'b0;
      first_q             <= 1'b1;
    end else begin
      o_platform_shutdown <= shutdown;
      o_xtal_en           <= !shutdown;
      // Suspend only counts once both cores have parked
      o_usb_clk_en        <= !(usb_susp_s && all_parked);
      // Wake goes straight to the pin, no core involvement
      o_pme_n             <= !(i_pme_enable && wake_s);
      // Host memory traffic waits for a running generator and no waking core
      o_mem_access_ok     <= pll_stable_q && gen_on && !(|waking);
      o_pd_vector         <= `DCPD_PD_VECTOR;
      o_reset_vector      <= `DCPD_RESET_VECTOR;
      first_q             <= 1'b0;
      o_boot_start        <= first_q && i_boot_mode;
    end
  end

endmodule

// ---- testbench/dcpd_ctrl_asserts.sv ----
module dcpd_ctrl_asserts (
  input wire        i_clk,                  // Clock
  input wire        i_rstn,                 // Reset
  input wire [1:0]  i_core_idle,            // IDLE
  input wire [1:0]  o_core_clk_en,          // Core clocks
  input wire [15:0] o_pd_vector,            // Vector
  input wire [19:0] o_reset_vector,         // Vector
  input wire        o_pll_en,               // Generator
  input wire        o_usb_clk_en,           // USB clocks
  input wire        o_platform_shutdown,    // Shutdown
  input wire        i_link_enable,          // Enable
  input wire        i_link_cold_req,        // Cold
  input wire        i_link_warm_req,        // Warm
  input wire        o_codec_reset_n,        // Codec reset
  input wire        o_sync,                 // SYNC
  input wire        o_sync_gen_enable,      // Sync gen
  input wire        o_link_ok,              // Link ok
  input wire        o_cold_reset_control    // Cold bit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [8:0] sync_cnt_q;
  // SYNC length is far beyond a repetition, so count it
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) sync_cnt_q <= 9'h000;
    else if (o_sync) sync_cnt_q <= sync_cnt_q + 9'h001;
    else sync_cnt_q <= 9'h000;
  end
  property p_vectors;
    o_pd_vector == 16'h0004 && o_reset_vector == 20'h10000;
  endproperty
  a_vectors: assert property (p_vectors) else $error("bad vector");
  property p_park_cause;
    ($past(o_core_clk_en) & ~o_core_clk_en & ~$past(i_core_idle)) == 2'h0;
  endproperty
  a_park_cause: assert property (p_park_cause) else $error("park without idle");
  property p_gen_off;
    !o_pll_en |-> o_core_clk_en == 2'h0;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("generator off early");
  property p_usb_off;
    !o_usb_clk_en |-> o_core_clk_en == 2'h0;
  endproperty
  a_usb_off: assert property (p_usb_off) else $error("usb clocks off early");
  property p_shutdown;
    o_platform_shutdown |-> o_core_clk_en == 2'h0 && !o_link_ok;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("bad shutdown");
  property p_link_held;
    o_link_ok && $rose(i_link_enable) && !i_link_cold_req && !i_link_warm_req
      |=> o_link_ok && !o_sync;
  endproperty
  a_link_held: assert property (p_link_held) else $error("enable disturbed link");
  property p_cold_release;
    $rose(o_codec_reset_n) |-> !o_cold_reset_control && $past(i_link_enable);
  endproperty
  a_cold_release: assert property (p_cold_release) else $error("bad cold release");
  property p_sync_len;
    $fell(o_sync) |-> sync_cnt_q == 9'h0FA;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("bad sync length");
  property p_link_ok;
    $rose(o_link_ok) |-> $past(o_sync_gen_enable);
  endproperty
  a_link_ok: assert property (p_link_ok) else $error("link ok early");
endmodule

// ---- testbench/dcpd_core_model.sv ----
module dcpd_core_model (
  input  wire       i_clk,    // Clock
  input  wire       i_irq,    // Powerdown irq
  input  wire       i_clk_en, // Core clock
  input  wire [1:0] i_mode,   // 0 idle, 1 early return, 2 late idle
  output logic      o_idle,   // IDLE pulse
  output logic      o_rti     // Return pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] state_q = 2'h0;
  logic [4:0] cnt_q   = 5'h00;
  initial o_idle = 1'b0;
  initial o_rti = 1'b0;
  always @(negedge i_clk) begin
    o_idle <= 1'b0;
    o_rti  <= 1'b0;
    if (i_irq) begin
      state_q <= 2'h1;
      cnt_q   <= (i_mode == 2'h2) ? 5'h14 : 5'h03;
    end else if (state_q == 2'h1) begin
      if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      else if (i_mode == 2'h1) begin
        o_rti   <= 1'b1;
        state_q <= 2'h0;
      end else begin
        o_idle  <= 1'b1;
        state_q <= 2'h2;
      end
    end else if (state_q == 2'h2) begin
      // Return only after clocks ran a while, so a park is not taken for a wake
      cnt_q <= i_clk_en ? cnt_q + 5'h01 : 5'h00;
      if (cnt_q == 5'h04) begin
        o_rti   <= 1'b1;
        state_q <= 2'h0;
      end
    end
  end
endmodule

// ---- testbench/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0]  i_reg_page = 8'h00, i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000, rdat;
  logic        i_boot_mode = 1'b1, i_crystal_force_on = 1'b0, i_usb_suspend = 1'b0;
  logic        i_pme_enable = 1'b0, i_wake_event = 1'b0, i_link_enable = 1'b0;
  logic        i_link_cold_req = 1'b0, i_link_warm_req = 1'b0;
  logic        i_bitclk_internal = 1'b1, i_bit_clock_ok = 1'b0;
  logic [1:0]  mode0 = 2'h0, mode1 = 2'h0, irq_seen;
  wire  [1:0]  i_core_idle, i_core_rti, o_core_irq, o_core_clk_en;
  wire  [15:0] o_reg_rdata, o_pd_vector;
  wire  [19:0] o_reset_vector;
  wire         o_reg_rvalid, o_boot_start, o_pll_en, o_xtal_en, o_mem_access_ok;
  wire         o_usb_clk_en, o_pme_n, o_platform_shutdown, o_codec_reset_n, o_sync;
  wire         o_bit_clock_gen_enable, o_sync_gen_enable, o_link_ok, o_cold_reset_control;
  int          errors = 0, check_count = 0, n;
  always #2 i_clk = ~i_clk;
  dcpd_ctrl #(.LOCK_SLOW_CYC(8), .LOCK_FAST_CYC(4)) u_dcpd_ctrl (
    .i_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_page, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_core_idle, .i_core_rti, .o_core_irq, .o_core_clk_en,
    .o_pd_vector, .o_reset_vector, .i_boot_mode, .o_boot_start, .i_crystal_force_on,
    .o_pll_en, .o_xtal_en, .o_mem_access_ok, .i_usb_suspend, .o_usb_clk_en, .i_pme_enable,
    .i_wake_event, .o_pme_n, .o_platform_shutdown, .i_link_enable, .i_link_cold_req,
    .i_link_warm_req, .i_bitclk_internal, .i_bit_clock_ok, .o_codec_reset_n, .o_sync,
    .o_bit_clock_gen_enable, .o_sync_gen_enable, .o_link_ok, .o_cold_reset_control);
  dcpd_core_model u_core_model0 (.i_clk, .i_irq(o_core_irq[0]), .i_clk_en(o_core_clk_en[0]),
    .i_mode(mode0), .o_idle(i_core_idle[0]), .o_rti(i_core_rti[0]));
  dcpd_core_model u_core_model1 (.i_clk, .i_irq(o_core_irq[1]), .i_clk_en(o_core_clk_en[1]),
    .i_mode(mode1), .o_idle(i_core_idle[1]), .o_rti(i_core_rti[1]));
  task automatic wrap_up;
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    irq_seen = o_core_irq;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string msg);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk(o_reg_rvalid, 1'b1, "read valid");
    chk(o_reg_rdata, exp, msg);
  endtask
  task automatic wait_en(input int k, input logic v);
    n = 0;
    while (o_core_clk_en[k] !== v) begin
      @(negedge i_clk);
      n++;
      if (n > 200) begin
        chk(o_core_clk_en[k], v, "clock enable wait");
        wrap_up();
      end
    end
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    chk(o_boot_start, 1'b1, "boot start");
    @(negedge i_clk);
    chk(o_boot_start, 1'b0, "boot pulse ends");
    chk({o_codec_reset_n, o_cold_reset_control, o_mem_access_ok}, 3'h3, "reset levels");
    rd(8'h08, 16'h0000, "core1 running");
    rd(8'h0C, 16'h0000, "unmapped");
    i_reg_page = 8'h01;
    wr(8'h08, 16'h0001);
    chk(irq_seen, 2'h0, "other page");
    i_reg_page = 8'h00;
    wr(8'h08, 16'h0001);
    chk(irq_seen, 2'h1, "core1 irq only");
    rd(8'h08, 16'h0002, "core1 in handler");
    wait_en(0, 1'b0);
    rd(8'h08, 16'h0003, "core1 parked");
    chk({o_core_clk_en[1], o_pll_en}, 2'h3, "core2 runs");
    wr(8'h0A, 16'h0001);
    wait_en(1, 1'b0);
    repeat (3) @(negedge i_clk);
    chk({o_pll_en, o_platform_shutdown, o_xtal_en}, 3'h2, "both parked");
    chk(o_mem_access_ok, 1'b0, "memory closed");
    i_usb_suspend = 1'b1;
    i_pme_enable = 1'b1;
    i_wake_event = 1'b1;
    repeat (4) @(negedge i_clk);
    chk({o_usb_clk_en, o_pme_n}, 2'h0, "suspend and wake");
    i_usb_suspend = 1'b0;
    i_wake_event = 1'b0;
    wr(8'h08, 16'h0002);
    wait_en(0, 1'b1);
    chk(n >= 7, 1'b1, "slow lock");
    repeat (8) @(negedge i_clk);
    rd(8'h08, 16'h0000, "core1 woke");
    chk(o_core_clk_en[1], 1'b0, "core2 parked");
    wr(8'h08, 16'h0001);
    wait_en(0, 1'b0);
    i_crystal_force_on = 1'b1;
    wr(8'h08, 16'h0002);
    wait_en(0, 1'b1);
    chk(n < 7, 1'b1, "fast lock");
    wr(8'h08, 16'h0001);
    n = 0;
    while (o_core_irq[0] !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_core_irq[0], 1'b1, "irq after return");
    wait_en(0, 1'b0);
    i_crystal_force_on = 1'b0;
    wr(8'h08, 16'h0002);
    wait_en(0, 1'b1);
    repeat (8) @(negedge i_clk);
    mode0 = 2'h2;
    wr(8'h08, 16'h0001);
    wr(8'h08, 16'h0002);
    n = 0;
    repeat (40) begin
      @(negedge i_clk);
      if (o_core_clk_en[0] !== 1'b1) n++;
    end
    chk(20'(n), 20'h00000, "clocks kept");
    rd(8'h08, 16'h0000, "passed idle");
    mode0 = 2'h1;
    wr(8'h08, 16'h0001);
    repeat (10) @(negedge i_clk);
    rd(8'h08, 16'h0000, "abandoned");
    i_link_enable = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({o_codec_reset_n, o_cold_reset_control, o_bit_clock_gen_enable}, 3'h5, "cold");
    i_bit_clock_ok = 1'b1;
    repeat (6) @(negedge i_clk);
    chk({o_sync_gen_enable, o_link_ok}, 2'h3, "link up");
    i_link_enable = 1'b0;
    @(negedge i_clk);
    i_link_enable = 1'b1;
    repeat (3) @(negedge i_clk);
    chk({o_link_ok, o_sync, o_codec_reset_n}, 3'h5, "enable while up");
    i_link_warm_req = 1'b1;
    i_link_enable = 1'b0;
    i_bit_clock_ok = 1'b0;
    @(negedge i_clk);
    i_link_warm_req = 1'b0;
    repeat (4) @(negedge i_clk);
    i_link_enable = 1'b1;
    n = 0;
    repeat (300) begin
      @(negedge i_clk);
      if (o_sync === 1'b1) n++;
    end
    chk(20'(n), 20'h000FA, "sync length");
    chk(o_bit_clock_gen_enable, 1'b1, "warm bit clock");
    wrap_up();
  end
endmodule
bind dcpd_ctrl dcpd_ctrl_asserts u_dcpd_ctrl_asserts (
  .i_clk, .i_rstn, .i_core_idle, .o_core_clk_en, .o_pd_vector, .o_reset_vector, .o_pll_en,
  .o_usb_clk_en, .o_platform_shutdown, .i_link_enable, .i_link_cold_req, .i_link_warm_req,
  .o_codec_reset_n, .o_sync, .o_sync_gen_enable, .o_link_ok, .o_cold_reset_control);
